/* File: src/timer_sync_defs.svh */
// register offsets, field positions, reset values and timing for the synchronous timer block
`ifndef TIMER_SYNC_DEFS_SVH
`define TIMER_SYNC_DEFS_SVH

`define ADDR_W 8
`define OFS_START 8'h00
`define OFS_SYNC_START 8'h04
`define OFS_U2_START 8'h08
`define OFS_M_CMP_A 8'h0c
`define OFS_M_CMP_B 8'h10
`define OFS_S_CMP_A 8'h14
`define OFS_S_CMP_B 8'h18
`define OFS_S_CMP_C 8'h1c
`define OFS_S_CMP_D 8'h20
`define OFS_Y_CMP_A 8'h24
`define OFS_Y_CMP_B 8'h28
`define OFS_U2_PERIOD 8'h2c
`define OFS_U2_DUTY0 8'h30
`define OFS_U2_DUTY1 8'h34
`define OFS_CTRL 8'h38
`define OFS_IRQ_STAT 8'h3c
`define OFS_IRQ_MASK 8'h40
`define OFS_M_COUNT 8'h44
`define OFS_S_COUNT 8'h48
`define OFS_Y_COUNT 8'h4c

`define CTL_CLR_A 0
`define CTL_CLR_B 1
`define CTL_SYNC_CLR 2
`define CTL_LINK_START 3
`define CTL_LINK_STOP 4
`define CTL_LINK_U2 5
`define CTL_W 6
`define CTL_RESET 6'h00

`define IRQ_M_A 0
`define IRQ_M_B 1
`define IRQ_SLAVE 2
`define IRQ_U2 3
`define IRQ_STOP 4
`define IRQ_W 5

`define CMP_RESET 32'h0000ffff
`define IRQ_DELAY_CYC 2
`define LINK_STOP_IDX 2'h2
`define CLK_PERIOD_NS 5
`define CARRIER_NS 100000
`define CARRIER_CYCLES (`CARRIER_NS / `CLK_PERIOD_NS)

`endif

/* File: src/timer_sync_pkg.sv */
// types shared by the synchronous timer block
package timer_sync_pkg;

  typedef struct packed {
    logic sync_ch;
    logic slave;
    logic master;
  } start_t;

  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } match_t;

endpackage : timer_sync_pkg

/* File: src/timer_sync_top.sv */
// synchronous start, stop and clear of master, slave, sync and second-unit timer channels
`timescale 1ns/1ps
`include "timer_sync_defs.svh"

module timer_sync_top #(
  parameter int CW = 16,
  parameter int CARRIER_CYCLES = `CARRIER_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // register port
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // event link
  input wire logic link_event_i,
  output logic unit2_cmp_a_event_o,
  output logic master_cmp_a_irq_o,
  output logic master_cmp_b_irq_o,
  // waveform outputs
  output logic master_out_a_o,
  output logic slave_out_a_o,
  output logic slave_out_c_o,
  output logic sync_out_o,
  output logic unit2_out0_o,
  output logic unit2_out1_o,
  // interrupt
  output logic irq_o
);

  generate
    // shift kept below 31 so the bound never overflows a signed int
    if (CW < 2 || CW > 32 || CARRIER_CYCLES < 2 || (CW < 31 && CARRIER_CYCLES > (1 << CW))) begin : g_bad_param
      $error("timer_sync_top: counter width or carrier length out of range");
    end
    // the interrupt pipe taps its second-last stage
    if (`IRQ_DELAY_CYC < 2) begin : g_bad_delay
      $error("timer_sync_top: interrupt delay below two cycles");
    end
  endgenerate

  localparam logic [CW-1:0] PERIOD_RESET = CW'(CARRIER_CYCLES - 1);
  localparam logic [CW-1:0] CMP_RESET = CW'(`CMP_RESET);

  function automatic logic hit(input logic run, input logic [CW-1:0] cnt, input logic [CW-1:0] cmp);
    hit = run && (cnt == cmp);
  endfunction : hit

  function automatic logic [CW-1:0] next_count(input logic run, input logic clr, input logic [CW-1:0] cnt);
    if (clr) begin
      next_count = '0;
    end else if (run) begin
      next_count = CW'(cnt + 1'b1);
    end else begin
      next_count = cnt;
    end
  endfunction : next_count

  function automatic logic wr_at(input logic wr, input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
    wr_at = wr && (a == ofs);
  endfunction : wr_at

  timer_sync_pkg::start_t start_bits;
  logic [1:0] unit2_start_reg;
  logic [CW-1:0] m_cmp_a;
  logic [CW-1:0] m_cmp_b;
  logic [CW-1:0] s_cmp_a;
  logic [CW-1:0] s_cmp_b;
  logic [CW-1:0] s_cmp_c;
  logic [CW-1:0] s_cmp_d;
  logic [CW-1:0] y_cmp_a;
  logic [CW-1:0] y_cmp_b;
  logic [CW-1:0] unit2_period_reg;
  logic [CW-1:0] unit2_duty_compare [0:1];
  logic [`CTL_W-1:0] ctrl;
  logic [`IRQ_W-1:0] irq_stat;
  logic [`IRQ_W-1:0] irq_mask;

  logic [CW-1:0] m_cnt;
  logic [CW-1:0] s_cnt;
  logic [CW-1:0] y_cnt;
  logic [CW-1:0] unit2_counter [0:1];

  timer_sync_pkg::match_t m_hit;
  timer_sync_pkg::match_t s_hit;
  timer_sync_pkg::match_t y_hit;
  logic [1:0] u2_duty_hit;
  logic [1:0] u2_end_hit;
  logic [`IRQ_DELAY_CYC-1:0] irq_a_pipe;
  logic [`IRQ_DELAY_CYC-1:0] irq_b_pipe;
  logic s_clr;
  logic y_clr;
  logic link_q;
  logic [1:0] link_cnt;
  logic link_stop;
  logic [`IRQ_W-1:0] irq_set;
  logic [31:0] next_rdata;

  // compare matches are judged only while a counter runs
  always_comb begin
    m_hit = '0;
    s_hit = '0;
    y_hit = '0;
    m_hit.a = hit(start_bits.master, m_cnt, m_cmp_a);
    m_hit.b = hit(start_bits.master, m_cnt, m_cmp_b);
    s_hit.a = hit(start_bits.slave, s_cnt, s_cmp_a);
    s_hit.b = hit(start_bits.slave, s_cnt, s_cmp_b);
    s_hit.c = hit(start_bits.slave, s_cnt, s_cmp_c);
    s_hit.d = hit(start_bits.slave, s_cnt, s_cmp_d);
    y_hit.a = hit(start_bits.sync_ch, y_cnt, y_cmp_a);
    y_hit.b = hit(start_bits.sync_ch, y_cnt, y_cmp_b);
    for (int i = 0; i < 2; i++) begin
      u2_duty_hit[i] = hit(unit2_start_reg[i], unit2_counter[i], unit2_duty_compare[i]);
      u2_end_hit[i] = hit(unit2_start_reg[i], unit2_counter[i], unit2_period_reg);
    end
  end

  // slave clears keyed to the delayed interrupt timing, the sync clear to the raw compare b match
  assign s_clr = (ctrl[`CTL_CLR_A] && irq_a_pipe[`IRQ_DELAY_CYC-1]) ||
                 (ctrl[`CTL_CLR_B] && irq_b_pipe[`IRQ_DELAY_CYC-1]);
  assign y_clr = ctrl[`CTL_SYNC_CLR] && m_hit.b;
  assign link_stop = link_q && ctrl[`CTL_LINK_STOP] && (link_cnt == `LINK_STOP_IDX);

  // shift registers give the interrupt its lag behind the raw match
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_a_pipe <= '0;
      irq_b_pipe <= '0;
    end else begin
      irq_a_pipe <= {irq_a_pipe[`IRQ_DELAY_CYC-2:0], m_hit.a};
      irq_b_pipe <= {irq_b_pipe[`IRQ_DELAY_CYC-2:0], m_hit.b};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      master_cmp_a_irq_o <= 1'b0;
      master_cmp_b_irq_o <= 1'b0;
      unit2_cmp_a_event_o <= 1'b0;
    end else begin
      master_cmp_a_irq_o <= irq_a_pipe[`IRQ_DELAY_CYC-2];
      master_cmp_b_irq_o <= irq_b_pipe[`IRQ_DELAY_CYC-2];
      unit2_cmp_a_event_o <= u2_duty_hit[0];
    end
  end

  // counters; a clear never touches a start bit
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      m_cnt <= '0;
      s_cnt <= '0;
      y_cnt <= '0;
    end else begin
      m_cnt <= next_count(start_bits.master, m_hit.b, m_cnt);
      s_cnt <= next_count(start_bits.slave, s_clr, s_cnt);
      y_cnt <= next_count(start_bits.sync_ch, y_clr, y_cnt);
    end
  end

  // both unit2 channels wrap on the one shared period register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2; i++) begin
        unit2_counter[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        unit2_counter[i] <= next_count(unit2_start_reg[i], u2_end_hit[i], unit2_counter[i]);
      end
    end
  end

  // waveform outputs; a skipped compare value never toggles
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      master_out_a_o <= 1'b0;
      slave_out_a_o <= 1'b0;
      slave_out_c_o <= 1'b0;
      sync_out_o <= 1'b0;
    end else begin
      if (m_hit.b) begin
        master_out_a_o <= 1'b0;
      end else if (m_hit.a) begin
        master_out_a_o <= 1'b1;
      end
      slave_out_a_o <= slave_out_a_o ^ (s_hit.a | s_hit.b);
      slave_out_c_o <= slave_out_c_o ^ (s_hit.c | s_hit.d);
      sync_out_o <= sync_out_o ^ (y_hit.a | y_hit.b);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      unit2_out0_o <= 1'b0;
      unit2_out1_o <= 1'b0;
    end else begin
      unit2_out0_o <= unit2_out0_o ^ u2_duty_hit[0];
      unit2_out1_o <= unit2_out1_o ^ (u2_duty_hit[1] ^ u2_end_hit[1]);
    end
  end

  // one register stage on the linked event; the action trails its source
  // the modulo-three count sees every event, enabled or not
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      link_q <= 1'b0;
      link_cnt <= '0;
    end else begin
      link_q <= link_event_i || (ctrl[`CTL_LINK_U2] && unit2_cmp_a_event_o);
      if (link_q) begin
        link_cnt <= (link_cnt == `LINK_STOP_IDX) ? 2'h0 : 2'(link_cnt + 1'b1);
      end
    end
  end

  // start bits: bus writes first, linked event on top
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      start_bits <= '0;
    end else begin
      timer_sync_pkg::start_t next_start;
      next_start = start_bits;
      if (wr_at(wr_i, addr_i, `OFS_START)) begin
        next_start = timer_sync_pkg::start_t'(wdata_i[2:0]);
      end
      if (wr_at(wr_i, addr_i, `OFS_SYNC_START)) begin
        next_start = next_start | timer_sync_pkg::start_t'(wdata_i[2:0]);
      end
      if (link_stop) begin
        next_start.master = 1'b0;
      end else if (link_q && ctrl[`CTL_LINK_START]) begin
        next_start.master = 1'b1;
        next_start.sync_ch = 1'b1;
      end
      start_bits <= next_start;
    end
  end

  // one write starts or stops both unit2 channels together
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      unit2_start_reg <= '0;
    end else if (wr_at(wr_i, addr_i, `OFS_U2_START)) begin
      unit2_start_reg <= wdata_i[1:0];
    end
  end

  // compare values take effect at the strobe edge; no buffer stage
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      m_cmp_a <= CMP_RESET;
      m_cmp_b <= CMP_RESET;
      s_cmp_a <= CMP_RESET;
      s_cmp_b <= CMP_RESET;
      s_cmp_c <= CMP_RESET;
      s_cmp_d <= CMP_RESET;
      y_cmp_a <= CMP_RESET;
      y_cmp_b <= CMP_RESET;
      unit2_period_reg <= PERIOD_RESET;
      unit2_duty_compare[0] <= CMP_RESET;
      unit2_duty_compare[1] <= CMP_RESET;
      ctrl <= `CTL_RESET;
    end else if (wr_i) begin
      case (addr_i)
        `OFS_M_CMP_A: m_cmp_a <= wdata_i[CW-1:0];
        `OFS_M_CMP_B: m_cmp_b <= wdata_i[CW-1:0];
        `OFS_S_CMP_A: s_cmp_a <= wdata_i[CW-1:0];
        `OFS_S_CMP_B: s_cmp_b <= wdata_i[CW-1:0];
        `OFS_S_CMP_C: s_cmp_c <= wdata_i[CW-1:0];
        `OFS_S_CMP_D: s_cmp_d <= wdata_i[CW-1:0];
        `OFS_Y_CMP_A: y_cmp_a <= wdata_i[CW-1:0];
        `OFS_Y_CMP_B: y_cmp_b <= wdata_i[CW-1:0];
        `OFS_U2_PERIOD: unit2_period_reg <= wdata_i[CW-1:0];
        `OFS_U2_DUTY0: unit2_duty_compare[0] <= wdata_i[CW-1:0];
        `OFS_U2_DUTY1: unit2_duty_compare[1] <= wdata_i[CW-1:0];
        `OFS_CTRL: ctrl <= wdata_i[`CTL_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status; a new event beats a same-cycle write-one clear
  always_comb begin
    irq_set = '0;
    irq_set[`IRQ_M_A] = irq_a_pipe[`IRQ_DELAY_CYC-1];
    irq_set[`IRQ_M_B] = irq_b_pipe[`IRQ_DELAY_CYC-1];
    irq_set[`IRQ_SLAVE] = |s_hit;
    irq_set[`IRQ_U2] = u2_duty_hit[0];
    irq_set[`IRQ_STOP] = link_stop;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_stat <= '0;
    end else if (wr_at(wr_i, addr_i, `OFS_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~wdata_i[`IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_mask <= '0;
    end else if (wr_at(wr_i, addr_i, `OFS_IRQ_MASK)) begin
      irq_mask <= wdata_i[`IRQ_W-1:0];
    end
  end

  // registered so the pin never glitches while status and mask settle
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // unmapped and write-only offsets read as zero
  always_comb begin
    next_rdata = '0;
    case (addr_i)
      `OFS_START: next_rdata[2:0] = start_bits;
      `OFS_U2_START: next_rdata[1:0] = unit2_start_reg;
      `OFS_M_CMP_A: next_rdata[CW-1:0] = m_cmp_a;
      `OFS_M_CMP_B: next_rdata[CW-1:0] = m_cmp_b;
      `OFS_S_CMP_A: next_rdata[CW-1:0] = s_cmp_a;
      `OFS_S_CMP_B: next_rdata[CW-1:0] = s_cmp_b;
      `OFS_S_CMP_C: next_rdata[CW-1:0] = s_cmp_c;
      `OFS_S_CMP_D: next_rdata[CW-1:0] = s_cmp_d;
      `OFS_Y_CMP_A: next_rdata[CW-1:0] = y_cmp_a;
      `OFS_Y_CMP_B: next_rdata[CW-1:0] = y_cmp_b;
      `OFS_U2_PERIOD: next_rdata[CW-1:0] = unit2_period_reg;
      `OFS_U2_DUTY0: next_rdata[CW-1:0] = unit2_duty_compare[0];
      `OFS_U2_DUTY1: next_rdata[CW-1:0] = unit2_duty_compare[1];
      `OFS_CTRL: next_rdata[`CTL_W-1:0] = ctrl;
      `OFS_IRQ_STAT: next_rdata[`IRQ_W-1:0] = irq_stat;
      `OFS_IRQ_MASK: next_rdata[`IRQ_W-1:0] = irq_mask;
      `OFS_M_COUNT: next_rdata[CW-1:0] = m_cnt;
      `OFS_S_COUNT: next_rdata[CW-1:0] = s_cnt;
      `OFS_Y_COUNT: next_rdata[CW-1:0] = y_cnt;
      default: next_rdata = '0;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : timer_sync_top

/* File: tb/timer_sync_asserts.sv */
// port-level checks for the synchronous timer block
`timescale 1ns/1ps
module timer_sync_asserts (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // register port
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // timer outputs
  input wire logic unit2_cmp_a_event_o,
  input wire logic master_cmp_a_irq_o,
  input wire logic master_cmp_b_irq_o,
  input wire logic master_out_a_o,
  input wire logic slave_out_c_o,
  input wire logic unit2_out0_o,
  input wire logic unit2_out1_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  chk_irqa_pulse: assert property (master_cmp_a_irq_o |=> !master_cmp_a_irq_o)
    else $error("compare a interrupt longer than one cycle");
  chk_irqb_pulse: assert property (master_cmp_b_irq_o |=> !master_cmp_b_irq_o)
    else $error("compare b interrupt longer than one cycle");
  // the pin follows the match at once, the interrupt trails it
  chk_out_rise: assert property ($rose(master_out_a_o) |-> ##[1:2] master_cmp_a_irq_o)
    else $error("master output rose without compare a");
  chk_out_fall: assert property ($fell(master_out_a_o) |-> ##[1:2] master_cmp_b_irq_o)
    else $error("master output fell without compare b");
  chk_u2ev_pulse: assert property (unit2_cmp_a_event_o |=> !unit2_cmp_a_event_o)
    else $error("unit2 event longer than one cycle");
  chk_u2_toggle: assert property ($changed(unit2_out0_o) |-> unit2_cmp_a_event_o)
    else $error("unit2 output 0 moved without duty match");
  chk_u2_event: assert property (unit2_cmp_a_event_o |-> $changed(unit2_out0_o))
    else $error("unit2 output 0 held on duty match");

  cover property (master_cmp_b_irq_o);
  cover property ($changed(slave_out_c_o));
  cover property (unit2_cmp_a_event_o && unit2_out1_o);
endmodule : timer_sync_asserts

bind timer_sync_top timer_sync_asserts u_timer_sync_asserts (
  .clk_sys_i(clk_sys_i),
  .reset_i(reset_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .unit2_cmp_a_event_o(unit2_cmp_a_event_o),
  .master_cmp_a_irq_o(master_cmp_a_irq_o),
  .master_cmp_b_irq_o(master_cmp_b_irq_o),
  .master_out_a_o(master_out_a_o),
  .slave_out_c_o(slave_out_c_o),
  .unit2_out0_o(unit2_out0_o),
  .unit2_out1_o(unit2_out1_o)
);

/* File: tb/link_partner.sv */
// event link source: one-cycle event a chosen number of cycles after a request
`timescale 1ns/1ps
module link_partner (
  // clock
  input wire logic clk_sys_i,
  // request
  input wire logic fire_i,
  input wire logic [3:0] lag_i,
  // event
  output logic link_event_o
);
  int n = -1;
  initial link_event_o = 1'b0;
  // a slow link proves the block does not count on a fixed lag
  always @(posedge clk_sys_i) begin
    link_event_o <= (n == 0);
    if (fire_i) n <= lag_i;
    else if (n >= 0) n <= n - 1;
  end
endmodule : link_partner

/* File: tb/timer_sync_top_bench.sv */
// self-checking bench for the synchronous timer block
`timescale 1ns/1ps
module timer_sync_top_bench;
  localparam int PER = 16;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, fire = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, got, m;
  logic link_event_i, ev, ia, ib, mo, sa, sc, so, u0, u1, irq;
  logic [7:0] ad [8] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h38, 8'h04};
  logic [31:0] dv [8] = '{32'h3, 32'h9, 32'h2, 32'h5, 32'h4, 32'h14, 32'h3, 32'h3};
  int mismatches = 0, samples_checked = 0, ta, tc, ts, hi;

  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  timer_sync_top #(.CARRIER_CYCLES(PER)) u_timer_sync_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .link_event_i(link_event_i), .unit2_cmp_a_event_o(ev), .master_cmp_a_irq_o(ia),
    .master_cmp_b_irq_o(ib), .master_out_a_o(mo), .slave_out_a_o(sa), .slave_out_c_o(sc),
    .sync_out_o(so), .unit2_out0_o(u0), .unit2_out1_o(u1), .irq_o(irq));
  link_partner u_link_partner (.clk_sys_i(clk_sys_i), .fire_i(fire), .lag_i(lag),
    .link_event_o(link_event_i));

  task automatic cw(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : cw
  task automatic cb(input logic g, input logic e);
    cw({31'h0, g}, {31'h0, e});
  endtask : cb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask : rd
  task automatic crd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cw(got, e);
  endtask : crd
  task automatic wait_ev;
    int i;
    i = 0;
    do begin
      @(posedge clk_sys_i);
      #1 i++;
    end while (ev !== 1'b1 && i < 40);
    cb(ev, 1'b1);
  endtask : wait_ev
  task automatic link(input logic [3:0] l);
    @(posedge clk_sys_i);
    fire <= 1'b1;
    lag <= l;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    repeat (l + 5) @(posedge clk_sys_i);
  endtask : link
  // toggles of the slave pins and high time of the master pin over n cycles
  task automatic watch(input int n);
    logic pa, pc, ps;
    ta = 0;
    tc = 0;
    ts = 0;
    hi = 0;
    @(posedge clk_sys_i);
    #1 pa = sa;
    pc = sc;
    ps = so;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1 ta += int'(sa !== pa);
      tc += int'(sc !== pc);
      ts += int'(so !== ps);
      hi += int'(mo === 1'b1);
      pa = sa;
      pc = sc;
      ps = so;
    end
  endtask : watch
  task automatic end_of_test;
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    crd(8'h0c, 32'h0000ffff);
    crd(8'h2c, PER - 1);
    crd(8'h04, 32'h0);
    crd(8'h50, 32'h0);
    wr(8'h04, 32'h5);
    crd(8'h00, 32'h5);
    wr(8'h00, 32'h0);
    rd(8'h44);
    m = got;
    crd(8'h4c, m);
    // equal duties: only a joint start makes both pins move together
    wr(8'h30, 32'h4);
    wr(8'h34, 32'h4);
    wr(8'h08, 32'h3);
    crd(8'h08, 32'h3);
    wait_ev();
    cb(u0, 1'b1);
    cb(u1, 1'b1);
    wait_ev();
    cb(u0, 1'b0);
    cb(u1, 1'b1);
    wr(8'h08, 32'h0);
    for (int i = 0; i < 8; i++) wr(ad[i], dv[i]);
    repeat (30) @(posedge clk_sys_i);
    watch(40);
    cw(ta, 12);
    cw(tc, 4);
    cw(hi, 24);
    crd(8'h00, 32'h3);
    wr(8'h00, 32'h0);
    repeat (5) @(posedge clk_sys_i);
    crd(8'h3c, 32'h0f);
    cb(irq, 1'b0);
    wr(8'h40, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    #1 cb(irq, 1'b1);
    wr(8'h3c, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    #1 cb(irq, 1'b0);
    crd(8'h3c, 32'h0d);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    wr(8'h0c, 32'h3);
    wr(8'h10, 32'h9);
    wr(8'h24, 32'h2);
    wr(8'h28, 32'h5);
    wr(8'h38, 32'h1c);
    link(4'h0);
    crd(8'h00, 32'h5);
    link(4'h3);
    crd(8'h00, 32'h5);
    link(4'h0);
    crd(8'h00, 32'h4);
    rd(8'h4c);
    m = got;
    crd(8'h4c, m + 2);
    link(4'h1);
    crd(8'h00, 32'h5);
    repeat (25) @(posedge clk_sys_i);
    rd(8'h44);
    m = got;
    crd(8'h4c, (m + 2) % 10);
    watch(40);
    cw(ts, 8);
    cw(hi, 24);
    // unit2 duty event as link source restarts the stopped master
    wr(8'h00, 32'h4);
    wr(8'h38, 32'h28);
    wr(8'h30, 32'h4);
    wr(8'h08, 32'h1);
    wait_ev();
    repeat (3) @(posedge clk_sys_i);
    crd(8'h00, 32'h5);
    crd(8'h3c, 32'h1b);
    end_of_test();
  end
endmodule : timer_sync_top_bench
